// File: include/gio_pkg.sv
/*
  Types shared by the I/O port block: register targets and the
  register access request carrier.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package gio_pkg;

  typedef enum logic [2:0] {
    GIO_T_DATA,
    GIO_T_SEL,
    GIO_T_DIR,
    GIO_T_INP,
    GIO_T_IEN,
    GIO_T_CTL,
    GIO_T_FLAG
  } gio_target_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        rmw;
    logic        bit_op;
    gio_target_t target;
    logic [1:0]  port;
    logic [2:0]  bit_idx;
    logic [7:0]  wdata;
  } gio_sfr_req_t;

endpackage : gio_pkg

// File: include/gio_regs.svh
/*
  Constants for the general purpose I/O port block: widths, masks,
  field positions, reset values and fixed pin positions.
  Assumes it is included once per compilation unit by bare name.
*/
`ifndef GIO_REGS_SVH
`define GIO_REGS_SVH

// ----------------------------------------------------------------
// Port geometry
// ----------------------------------------------------------------
`define GIO_PORTS        3
`define GIO_PINS         21
`define GIO_PORT_MASKS   24'h1F_FFFF
`define GIO_LED_PINS     21'h0_0300
`define GIO_AUDIO_PINS   21'h0_003C

// ----------------------------------------------------------------
// Port interrupt control fields
// ----------------------------------------------------------------
`define GIO_CTL_EDGE_P0  0
`define GIO_CTL_EDGE_P1  1
`define GIO_CTL_EDGE_P2  2
`define GIO_CTL_P0_LOW   3
`define GIO_CTL_P0_HIGH  4
`define GIO_CTL_P2_EN    5

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define GIO_RST_BYTE     8'h00
`define GIO_RST_CTL      6'h00
`define GIO_RST_PINS     21'h0_0000

// ----------------------------------------------------------------
// Mode codes, fixed pins and synchroniser warm-up count
// ----------------------------------------------------------------
`define GIO_SLEEP_ACTIVE 2'h0
`define GIO_PM_ACTIVE    2'h0
`define GIO_DMA0_PIN     1
`define GIO_DMA1_PIN     11
`define GIO_WARM_DONE    2'h3

`endif

// File: rtl/gio_edge_sync.sv
/*
  Two-stage synchroniser with edge detect for a group of pins.
  Assumes raw pins are asynchronous levels; edges are held off
  until the pipeline has filled after reset.
*/
`timescale 1ns/10ps
`include "gio_regs.svh"

module gio_edge_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst_n,
  // Pins and results
  input  wire logic [WIDTH-1:0] raw,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] sync;
  logic [WIDTH-1:0] prev;
  logic [1:0]       warm;
  wire              armed = (warm == `GIO_WARM_DONE);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      sync <= '0;
      prev <= '0;
      warm <= 2'h0;
    end else begin
      meta <= raw;
      sync <= meta;
      prev <= sync;
      if (!armed) begin
        warm <= warm + 2'h1;
      end
    end
  end

  assign level = sync;
  assign rise  = armed ? (sync & ~prev) : '0;
  assign fall  = armed ? (~sync & prev) : '0;

endmodule : gio_edge_sync

// File: rtl/gio_ports.sv
/*
  Three-port general purpose I/O block with edge interrupts and two
  pin-driven DMA triggers.
  Assumes register access arrives as one request per cycle on
  sfr_req, and that pads resolve pin_out/pin_oe and the pull enables.
*/
// Notes on behaviour
// - Two 8-bit ports and one 5-bit port
// - Port registers byte and bit addressable
// - Per-pin function select, reset to GPIO
// - Audio serial enable overrides function select
// - Direction bit, 1 means output, reset input
// - Normal port read returns pin levels
// - Bit read-modify-write uses latch value
// - Pull-up default, input mode 1 disables
// - LED pins have no pull
// - Low power keeps pin mode and value
// - Any enabled pin interrupt can wake chip
// - Programmable rising or falling edge per port
// - One CPU interrupt enable per port
// - Port one has per-bit enables
// - Port zero nibble enables, port two common
// - Status flag sets regardless of enable
// - CPU flag needs a covering enable set
// - Port interrupts blocked unless sleep mode 00
// - DMA trigger zero on port zero bit one rise
// - DMA trigger one on port one bit three fall
`timescale 1ns/10ps
`include "gio_regs.svh"

module gio_ports (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 rstn,
  // Register access
  input  wire gio_pkg::gio_sfr_req_t sfr_req,
  output logic [7:0]                sfr_rdata,
  output logic                      sfr_rvalid,
  // Pads
  input  wire logic [20:0]          pin_in,
  output logic      [20:0]          pin_out,
  output logic      [20:0]          pin_oe,
  output logic      [20:0]          pin_pull_up,
  output logic      [20:0]          pin_pull_down,
  // Peripheral and audio serial pin drive
  input  wire logic [20:0]          periph_out,
  input  wire logic [20:0]          periph_oe,
  input  wire logic                 audio_serial_enable,
  input  wire logic [20:0]          audio_out,
  input  wire logic [20:0]          audio_oe,
  // Pull direction per port, 1 selects pull-down
  input  wire logic [2:0]           pull_down_select,
  // Power state
  input  wire logic [1:0]           sleep_mode,
  input  wire logic [1:0]           power_mode,
  // CPU interrupt side
  input  wire logic [2:0]           cpu_int_enable,
  input  wire logic [2:0]           cpu_flag_clear,
  output logic      [2:0]           cpu_int_flags,
  output logic      [2:0]           port_irq,
  output logic                      wake_request,
  // DMA triggers
  output logic                      dma_trigger_zero,
  output logic                      dma_trigger_one
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'h0;
      rst_n    <= 1'h0;
    end else begin
      rst_meta <= 1'h1;
      rst_n    <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] pick(input logic [2:0][7:0] arr,
                                      input logic [1:0]      idx);
    logic [7:0] res;
    res = 8'h00;
    unique case (idx)
      2'h0:    res = arr[0];
      2'h1:    res = arr[1];
      2'h2:    res = arr[2];
      default: res = 8'h00;
    endcase
    return res;
  endfunction : pick

  function automatic logic [20:0] flat(input logic [2:0][7:0] arr);
    return {arr[2][4:0], arr[1], arr[0]};
  endfunction : flat

  function automatic logic [2:0][7:0] unflat(input logic [20:0] v);
    return {3'h0, v[20:16], v[15:8], v[7:0]};
  endfunction : unflat

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [2:0][7:0] port_latch;
  logic [2:0][7:0] pin_function_select;
  logic [2:0][7:0] pin_direction;
  logic [2:0][7:0] pin_input_mode;
  logic [2:0][7:0] port_int_flags;
  logic [7:0]      port_one_bit_int_enables;
  logic [5:0]      port_interrupt_control;

  wire [2:0][7:0] port_mask = `GIO_PORT_MASKS;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [20:0] pin_level;
  logic [20:0] pin_rise;
  logic [20:0] pin_fall;

  gio_edge_sync #(.WIDTH(`GIO_PINS)) u_sync (
    .clock (clock),
    .rst_n (rst_n),
    .raw   (pin_in),
    .level (pin_level),
    .rise  (pin_rise),
    .fall  (pin_fall)
  );

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  gio_pkg::gio_target_t tgt;
  assign tgt = sfr_req.target;

  wire       wr_go    = sfr_req.valid & sfr_req.write;
  wire       rd_go    = sfr_req.valid & ~sfr_req.write;
  wire [7:0] bit_mask = 8'h01 << sfr_req.bit_idx;
  wire [1:0] pidx     = sfr_req.port;

  wire [7:0] sel_latch = pick(port_latch, pidx);
  wire [7:0] sel_func  = pick(pin_function_select, pidx);
  wire [7:0] sel_dir   = pick(pin_direction, pidx);
  wire [7:0] sel_inp   = pick(pin_input_mode, pidx);
  wire [7:0] sel_flag  = pick(port_int_flags, pidx);
  wire [7:0] sel_pins  = pick(unflat(pin_level), pidx);

  wire [7:0] old_byte =
    (tgt == gio_pkg::GIO_T_DATA) ? sel_latch :
    (tgt == gio_pkg::GIO_T_SEL)  ? sel_func  :
    (tgt == gio_pkg::GIO_T_DIR)  ? sel_dir   :
    (tgt == gio_pkg::GIO_T_INP)  ? sel_inp   :
    (tgt == gio_pkg::GIO_T_FLAG) ? sel_flag  :
    (tgt == gio_pkg::GIO_T_IEN)  ? port_one_bit_int_enables :
    {2'h0, port_interrupt_control};

  wire [7:0] bit_val = sfr_req.wdata[0] ? bit_mask : 8'h00;
  wire [7:0] merged  = sfr_req.bit_op ?
                       ((old_byte & ~bit_mask) | bit_val) :
                       sfr_req.wdata;

  wire latch_read = sfr_req.rmw & sfr_req.bit_op;
  wire [7:0] rd_byte =
    ((tgt == gio_pkg::GIO_T_DATA) && !latch_read) ?
    sel_pins : old_byte;

  wire [7:0] next_rdata = sfr_req.bit_op ?
                          {7'h00, rd_byte[sfr_req.bit_idx]} : rd_byte;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata  <= `GIO_RST_BYTE;
      sfr_rvalid <= 1'h0;
    end else begin
      sfr_rvalid <= rd_go;
      if (rd_go) begin
        sfr_rdata <= next_rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt events
  // ----------------------------------------------------------------
  wire [20:0] func_f  = flat(pin_function_select);
  wire [20:0] dir_f   = flat(pin_direction);
  wire [20:0] latch_f = flat(port_latch);
  wire [20:0] inp_f   = flat(pin_input_mode);
  wire [20:0] flag_f  = flat(port_int_flags);
  wire [20:0] gpio_in = ~func_f & ~dir_f;

  wire [20:0] falling_sel = {
    {5{port_interrupt_control[`GIO_CTL_EDGE_P2]}},
    {8{port_interrupt_control[`GIO_CTL_EDGE_P1]}},
    {8{port_interrupt_control[`GIO_CTL_EDGE_P0]}}
  };

  wire [20:0] pin_event = gpio_in &
    ((falling_sel & pin_fall) | (~falling_sel & pin_rise));

  wire [2:0][7:0] flag_set = unflat(pin_event);

  wire [20:0] en_cover = {
    {5{port_interrupt_control[`GIO_CTL_P2_EN]}},
    port_one_bit_int_enables,
    {4{port_interrupt_control[`GIO_CTL_P0_HIGH]}},
    {4{port_interrupt_control[`GIO_CTL_P0_LOW]}}
  };

  wire [20:0] pend_f  = flag_f & en_cover;
  wire [2:0]  pending = {|pend_f[20:16], |pend_f[15:8], |pend_f[7:0]};
  wire        awake   = (sleep_mode == `GIO_SLEEP_ACTIVE);
  wire [2:0]  cpu_set = pending & {3{awake}};

  // Level driven: a CPU flag cleared while its module flag is
  // still pending comes straight back while sleep mode is 00.
  wire [2:0] next_cpu_flags = cpu_set |
                              (cpu_int_flags & ~cpu_flag_clear);

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  genvar gp;
  generate
    for (gp = 0; gp < `GIO_PORTS; gp++) begin : g_port
      wire hit = wr_go & (pidx == 2'(gp));
      wire [7:0] wv = merged & port_mask[gp];

      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          port_latch[gp]          <= `GIO_RST_BYTE;
          pin_function_select[gp] <= `GIO_RST_BYTE;
          pin_direction[gp]       <= `GIO_RST_BYTE;
          pin_input_mode[gp]      <= `GIO_RST_BYTE;
        end else if (hit) begin
          if (tgt == gio_pkg::GIO_T_DATA) begin
            port_latch[gp] <= wv;
          end
          if (tgt == gio_pkg::GIO_T_SEL) begin
            pin_function_select[gp] <= wv;
          end
          if (tgt == gio_pkg::GIO_T_DIR) begin
            pin_direction[gp] <= wv;
          end
          if (tgt == gio_pkg::GIO_T_INP) begin
            pin_input_mode[gp] <= wv;
          end
        end
      end

      // Hardware set wins over a software clear in the same cycle
      wire       flag_hit  = hit & (tgt == gio_pkg::GIO_T_FLAG);
      wire [7:0] flag_keep = flag_hit ? (port_int_flags[gp] & wv) :
                                        port_int_flags[gp];

      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          port_int_flags[gp] <= `GIO_RST_BYTE;
        end else begin
          port_int_flags[gp] <= (flag_keep | flag_set[gp]) &
                                port_mask[gp];
        end
      end
    end
  endgenerate

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      port_one_bit_int_enables <= `GIO_RST_BYTE;
      port_interrupt_control   <= `GIO_RST_CTL;
    end else if (wr_go) begin
      if (tgt == gio_pkg::GIO_T_IEN) begin
        port_one_bit_int_enables <= merged;
      end
      if (tgt == gio_pkg::GIO_T_CTL) begin
        port_interrupt_control <= merged[5:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Pad drive
  // ----------------------------------------------------------------
  wire [20:0] audio_own = {21{audio_serial_enable}} & `GIO_AUDIO_PINS;
  wire [20:0] gpio_own  = ~audio_own & ~func_f;
  wire [20:0] per_own   = ~audio_own & func_f;

  wire [20:0] next_out = (audio_own & audio_out) |
                         (per_own & periph_out) |
                         (gpio_own & latch_f);
  wire [20:0] next_oe  = (audio_own & audio_oe) |
                         (per_own & periph_oe) |
                         (gpio_own & dir_f);

  wire [20:0] pd_sel = {
    {5{pull_down_select[2]}},
    {8{pull_down_select[1]}},
    {8{pull_down_select[0]}}
  };
  wire [20:0] pull_en = ~next_oe & ~inp_f & ~`GIO_LED_PINS;

  wire run_mode = (power_mode == `GIO_PM_ACTIVE);

  // Outputs freeze while any low-power mode is in force
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_out       <= `GIO_RST_PINS;
      pin_oe        <= `GIO_RST_PINS;
      pin_pull_up   <= `GIO_RST_PINS;
      pin_pull_down <= `GIO_RST_PINS;
    end else if (run_mode) begin
      pin_out       <= next_out;
      pin_oe        <= next_oe;
      pin_pull_up   <= pull_en & ~pd_sel;
      pin_pull_down <= pull_en & pd_sel;
    end
  end

  // ----------------------------------------------------------------
  // CPU interrupt, wake and DMA outputs
  // ----------------------------------------------------------------
  wire next_wake = |(pin_event & en_cover);
  wire next_dma0 = pin_rise[`GIO_DMA0_PIN] &
                   gpio_in[`GIO_DMA0_PIN];
  wire next_dma1 = pin_fall[`GIO_DMA1_PIN] &
                   gpio_in[`GIO_DMA1_PIN];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cpu_int_flags    <= 3'h0;
      port_irq         <= 3'h0;
      wake_request     <= 1'h0;
      dma_trigger_zero <= 1'h0;
      dma_trigger_one  <= 1'h0;
    end else begin
      cpu_int_flags    <= next_cpu_flags;
      port_irq         <= next_cpu_flags & cpu_int_enable;
      wake_request     <= next_wake;
      dma_trigger_zero <= next_dma0;
      dma_trigger_one  <= next_dma1;
    end
  end

endmodule : gio_ports

// File: verification/gio_pad_model.sv
/*
  Pads and external devices on the 21 I/O pins.
  Assumes the bench sets ext_val and ext_oe away from the rising edge.
*/
`timescale 1ns/10ps

module gio_pad_model (
  // Clock
  input wire logic        clock,
  // Block side
  input wire logic [20:0] pin_out,
  input wire logic [20:0] pin_oe,
  input wire logic [20:0] pin_pull_up,
  input wire logic [20:0] pin_pull_down,
  // External device side
  input wire logic [20:0] ext_val,
  input wire logic [20:0] ext_oe,
  // Resolved levels
  output logic     [20:0] pin_in
);
  logic [20:0] drift = 21'h0_0000;

  // Floating pins wander so a stale level never reads as valid
  always_ff @(posedge clock) drift <= ~drift;

  always_comb begin
    for (int i = 0; i < 21; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_oe[i]) pin_in[i] = ext_val[i];
      else if (pin_pull_up[i]) pin_in[i] = 1'b1;
      else if (pin_pull_down[i]) pin_in[i] = 1'b0;
      else pin_in[i] = drift[i];
    end
  end
endmodule : gio_pad_model

// File: verification/gio_ports_chk.sv
/*
  Concurrent checks on the I/O port block's ports.
  Assumes it is bound to gio_ports and requests wait for reset release.
*/
`timescale 1ns/10ps

module gio_ports_chk (
  // Clock and reset
  input wire logic                  clock,
  input wire logic                  rstn,
  // Register access
  input wire gio_pkg::gio_sfr_req_t sfr_req,
  input wire logic [7:0]            sfr_rdata,
  input wire logic                  sfr_rvalid,
  // Pads
  input wire logic [20:0]           pin_in,
  input wire logic [20:0]           pin_out,
  input wire logic [20:0]           pin_oe,
  input wire logic [20:0]           pin_pull_up,
  input wire logic [20:0]           pin_pull_down,
  // Power and interrupts
  input wire logic [1:0]            sleep_mode,
  input wire logic [1:0]            power_mode,
  input wire logic [2:0]            cpu_int_enable,
  input wire logic [2:0]            cpu_int_flags,
  input wire logic [2:0]            port_irq,
  input wire logic                  dma_trigger_zero,
  input wire logic                  dma_trigger_one
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  a_read_answer: assert property (sfr_req.valid && !sfr_req.write |=> sfr_rvalid)
    else $error("read not answered");
  a_write_silent: assert property (sfr_req.valid && sfr_req.write |=> !sfr_rvalid)
    else $error("write answered");
  a_bit_read_lsb: assert property (sfr_req.valid && !sfr_req.write && sfr_req.bit_op
    |=> sfr_rdata[7:1] == 7'h00) else $error("bit read upper bits set");
  a_port_two_width: assert property (sfr_req.valid && !sfr_req.write
    && !sfr_req.bit_op && sfr_req.port == 2'h2 |=> sfr_rdata[7:5] == 3'h0)
    else $error("port two upper bits set");
  a_led_no_pull: assert property ((pin_pull_up[9:8] | pin_pull_down[9:8]) == 2'h0)
    else $error("pull on led pin");
  a_dma_zero_edge: assert property (dma_trigger_zero
    |-> $past(pin_in[1], 3) && !$past(pin_in[1], 4)) else $error("dma zero without rise");
  a_dma_one_edge: assert property (dma_trigger_one
    |-> !$past(pin_in[11], 3) && $past(pin_in[11], 4)) else $error("dma one without fall");
  a_dma_single: assert property (dma_trigger_zero |=> !dma_trigger_zero)
    else $error("dma zero pulse too long");
  a_irq_gate: assert property (port_irq == (cpu_int_flags & $past(cpu_int_enable)))
    else $error("port irq not flag and enable");
  a_sleep_blocks: assert property (sleep_mode != 2'h0 && cpu_int_flags == 3'h0
    |=> cpu_int_flags == 3'h0) else $error("cpu flag set in sleep");
  a_low_power_hold: assert property (power_mode != 2'h0
    |=> $stable(pin_out) && $stable(pin_oe)) else $error("pads moved in low power");
endmodule : gio_ports_chk

bind gio_ports gio_ports_chk gio_ports_chk_inst (
  .clock(clock), .rstn(rstn), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
  .sfr_rvalid(sfr_rvalid), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
  .pin_pull_up(pin_pull_up), .pin_pull_down(pin_pull_down), .sleep_mode(sleep_mode),
  .power_mode(power_mode), .cpu_int_enable(cpu_int_enable), .cpu_int_flags(cpu_int_flags),
  .port_irq(port_irq), .dma_trigger_zero(dma_trigger_zero), .dma_trigger_one(dma_trigger_one)
);

// File: verification/tb.sv
/*
  Self-checking bench for the I/O port block.
  Assumes reads answer one cycle after the request and pin events
  show three to four cycles after the pin moves.
*/
`timescale 1ns/10ps

module tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic                  clock = 1'b0;
  logic                  rstn = 1'b0;
  gio_pkg::gio_sfr_req_t sfr_req = '0;
  logic [7:0]            sfr_rdata;
  logic                  sfr_rvalid, audio_serial_enable = 1'b0, wake_request, dma0, dma1;
  logic [20:0]           pin_in, pin_out, pin_oe, pin_pull_up, pin_pull_down;
  logic [20:0]           periph_out = 21'h0_0000, periph_oe = 21'h0_0000;
  logic [20:0]           audio_out = 21'h0_0000, audio_oe = 21'h0_0000;
  logic [20:0]           ext_val = 21'h0_0000, ext_oe = 21'h1F_FFFF;
  logic [2:0]            pull_down_select = 3'h0, cpu_int_enable = 3'h0;
  logic [2:0]            cpu_flag_clear = 3'h0, cpu_int_flags, port_irq;
  logic [1:0]            sleep_mode = 2'h0, power_mode = 2'h0;
  int                    miscompares = 0, n_checks = 0, cycles = 0;
  int                    n_dma0 = 0, n_dma1 = 0, n_wake = 0;

  gio_ports gio_ports_inst (.clock(clock), .rstn(rstn), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pull_up(pin_pull_up), .pin_pull_down(pin_pull_down),
    .periph_out(periph_out), .periph_oe(periph_oe), .audio_serial_enable(audio_serial_enable),
    .audio_out(audio_out), .audio_oe(audio_oe), .pull_down_select(pull_down_select),
    .sleep_mode(sleep_mode), .power_mode(power_mode), .cpu_int_enable(cpu_int_enable),
    .cpu_flag_clear(cpu_flag_clear), .cpu_int_flags(cpu_int_flags), .port_irq(port_irq),
    .wake_request(wake_request), .dma_trigger_zero(dma0), .dma_trigger_one(dma1));

  gio_pad_model gio_pad_model_inst (.clock(clock), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pull_up(pin_pull_up), .pin_pull_down(pin_pull_down), .ext_val(ext_val),
    .ext_oe(ext_oe), .pin_in(pin_in));

  always #10 clock = ~clock;

  // Event counters and hang guard
  always @(posedge clock) begin
    cycles = cycles + 1;
    n_dma0 = n_dma0 + int'(dma0);
    n_dma1 = n_dma1 + int'(dma1);
    n_wake = n_wake + int'(wake_request);
    if (cycles == 3000) begin
      miscompares = miscompares + 1;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic sfr(input logic wr, rmw, bop, input gio_pkg::gio_target_t tg,
                     input logic [1:0] pt, input logic [2:0] ix, input logic [7:0] wd,
                     output logic [7:0] rd);
    // Two idle cycles let a pin change clear the synchroniser first
    repeat (2) @(negedge clock);
    sfr_req = '{1'b1, wr, rmw, bop, tg, pt, ix, wd};
    @(negedge clock);
    rd = sfr_rdata;
    if (!wr) chk("read valid", 32'h1, {31'h0, sfr_rvalid});
    sfr_req.valid = 1'b0;
    @(negedge clock);
  endtask : sfr

  task automatic wr(input gio_pkg::gio_target_t tg, input logic [1:0] pt, input logic [7:0] wd);
    logic [7:0] d;
    sfr(1'b1, 1'b0, 1'b0, tg, pt, 3'h0, wd, d);
  endtask : wr

  task automatic rchk(input string what, input logic rmw, bop, input gio_pkg::gio_target_t tg,
                      input logic [1:0] pt, input logic [2:0] ix, input logic [7:0] exp);
    logic [7:0] d;
    sfr(1'b0, rmw, bop, tg, pt, ix, 8'h00, d);
    chk(what, exp, d);
  endtask : rchk

  task automatic edge_to(input int i, input logic v);
    @(negedge clock);
    ext_val[i] = v;
    repeat (5) @(negedge clock);
  endtask : edge_to

  task automatic clr(input logic [1:0] p);
    wr(gio_pkg::GIO_T_FLAG, p, 8'h00);
    cpu_flag_clear = 3'h7;
    @(negedge clock);
    cpu_flag_clear = 3'h0;
  endtask : clr

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk("oe", 21'h0_0000, pin_oe);
    chk("pull up", 21'h1F_FCFF, pin_pull_up);
    rchk("sel", 1'b0, 1'b0, gio_pkg::GIO_T_SEL, 2'h0, 3'h0, 8'h00);
    ext_val = 21'h15_36A5;
    rchk("p0", 1'b0, 1'b0, gio_pkg::GIO_T_DATA, 2'h0, 3'h0, 8'hA5);
    rchk("p1", 1'b0, 1'b0, gio_pkg::GIO_T_DATA, 2'h1, 3'h0, 8'h36);
    rchk("p2", 1'b0, 1'b0, gio_pkg::GIO_T_DATA, 2'h2, 3'h0, 8'h15);
    ext_val = 21'h0_0000;
    ext_oe = 21'h1F_FF0F;
    rchk("pulled", 1'b0, 1'b0, gio_pkg::GIO_T_DATA, 2'h0, 3'h0, 8'hF0);
    wr(gio_pkg::GIO_T_INP, 2'h0, 8'hF0);
    chk("pull off", 8'h0F, pin_pull_up[7:0]);
    pull_down_select = 3'h1;
    repeat (2) @(negedge clock);
    chk("pull down", 16'h0F00, {pin_pull_down[7:0], pin_pull_up[7:0]});
    pull_down_select = 3'h0;
    ext_oe = 21'h1F_FFFF;
  endtask : t_reset

  task automatic t_dir_rmw();
    logic [7:0] d;
    wr(gio_pkg::GIO_T_DIR, 2'h1, 8'hF0);
    wr(gio_pkg::GIO_T_DATA, 2'h1, 8'hA5);
    chk("dir out", 12'hF0A, {pin_oe[15:8], pin_out[15:12]});
    rchk("pin bit", 1'b0, 1'b1, gio_pkg::GIO_T_DATA, 2'h1, 3'h0, 8'h00);
    rchk("latch bit", 1'b1, 1'b1, gio_pkg::GIO_T_DATA, 2'h1, 3'h0, 8'h01);
    rchk("rmw byte", 1'b1, 1'b0, gio_pkg::GIO_T_DATA, 2'h1, 3'h0, 8'hA0);
    sfr(1'b1, 1'b0, 1'b1, gio_pkg::GIO_T_DIR, 2'h1, 3'h0, 8'h01, d);
    chk("bit dir", 8'hF1, pin_oe[15:8]);
    rchk("driven bit", 1'b0, 1'b1, gio_pkg::GIO_T_DATA, 2'h1, 3'h0, 8'h01);
  endtask : t_dir_rmw

  task automatic t_select();
    periph_out = 21'h0_0001;
    periph_oe = 21'h0_0001;
    wr(gio_pkg::GIO_T_SEL, 2'h0, 8'h01);
    chk("periph", 2'h3, {pin_oe[0], pin_out[0]});
    audio_serial_enable = 1'b1;
    audio_oe = 21'h0_003C;
    audio_out = 21'h0_0028;
    repeat (2) @(negedge clock);
    chk("audio", 12'hFA5, {pin_oe[5:2], pin_out[5:2], pin_oe[1:0], pin_out[1:0]});
    audio_serial_enable = 1'b0;
    periph_oe = 21'h0_0000;
    wr(gio_pkg::GIO_T_SEL, 2'h0, 8'h00);
  endtask : t_select

  task automatic t_port0_irq();
    int d0;
    clr(2'h0);
    clr(2'h1);
    clr(2'h2);
    cpu_int_enable = 3'h7;
    wr(gio_pkg::GIO_T_CTL, 2'h0, 8'h08);
    d0 = n_dma0;
    edge_to(1, 1'b1);
    rchk("flag p0", 1'b0, 1'b0, gio_pkg::GIO_T_FLAG, 2'h0, 3'h0, 8'h02);
    chk("cpu p0", 6'h09, {cpu_int_flags, port_irq});
    chk("dma0", d0 + 1, n_dma0);
    chk("wake", 1, n_wake);
    edge_to(1, 1'b0);
    clr(2'h0);
    chk("cpu cleared", 3'h0, cpu_int_flags);
    wr(gio_pkg::GIO_T_SEL, 2'h0, 8'h02);
    edge_to(1, 1'b1);
    chk("dma0 sel", d0 + 1, n_dma0);
    wr(gio_pkg::GIO_T_SEL, 2'h0, 8'h00);
    edge_to(1, 1'b0);
  endtask : t_port0_irq

  task automatic t_port1_irq();
    wr(gio_pkg::GIO_T_CTL, 2'h0, 8'h02);
    wr(gio_pkg::GIO_T_IEN, 2'h1, 8'h08);
    edge_to(11, 1'b1);
    edge_to(11, 1'b0);
    chk("dma1", 1, n_dma1);
    rchk("flag p1", 1'b0, 1'b0, gio_pkg::GIO_T_FLAG, 2'h1, 3'h0, 8'h08);
    chk("cpu p1", 3'h2, cpu_int_flags);
    clr(2'h1);
    edge_to(10, 1'b1);
    edge_to(10, 1'b0);
    rchk("flag p1 b2", 1'b0, 1'b0, gio_pkg::GIO_T_FLAG, 2'h1, 3'h0, 8'h04);
    chk("cpu p1 off", 3'h0, cpu_int_flags);
    clr(2'h1);
  endtask : t_port1_irq

  task automatic t_port2_sleep();
    int wk;
    wr(gio_pkg::GIO_T_CTL, 2'h0, 8'h20);
    sleep_mode = 2'h1;
    wk = n_wake;
    edge_to(16, 1'b1);
    rchk("flag p2", 1'b0, 1'b0, gio_pkg::GIO_T_FLAG, 2'h2, 3'h0, 8'h01);
    chk("cpu sleep", 3'h0, cpu_int_flags);
    chk("wake sleep", wk + 1, n_wake);
    clr(2'h2);
    sleep_mode = 2'h0;
    edge_to(17, 1'b1);
    chk("cpu p2", 3'h4, cpu_int_flags);
  endtask : t_port2_sleep

  task automatic t_low_power();
    power_mode = 2'h2;
    wr(gio_pkg::GIO_T_DATA, 2'h1, 8'h5A);
    wr(gio_pkg::GIO_T_DIR, 2'h1, 8'h00);
    chk("frozen", 12'hF1A, {pin_oe[15:8], pin_out[15:12]});
    power_mode = 2'h0;
    repeat (2) @(negedge clock);
    chk("thawed", 12'h005, {pin_oe[15:8], pin_out[15:12]});
  endtask : t_low_power

  initial begin
    repeat (3) @(negedge clock);
    rstn = 1'b1;
    repeat (4) @(negedge clock);
    t_reset();
    t_dir_rmw();
    t_select();
    t_port0_irq();
    t_port1_irq();
    t_port2_sleep();
    t_low_power();
    close_out();
  end
endmodule : tb
